/* File: rtl/serial_function_control_latch.sv */
// Serial-loaded function control latch with transmit/receive control
`timescale 1ns/1ps
module serial_function_control_latch #(
    parameter int HOLD_CYCLES = sfcl_pkg::TONE_HOLD_CYCLES  // Tone hold length
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic serialClk,
    input wire logic serialData,
    input wire logic controlLoadStrobe,
    input wire logic pushToTalk,
    input wire logic toneKeyInput,
    output logic lowPowerSelect,
    output logic squelchHoldEnable_n,
    output logic txAudioMute_n,
    output logic amEquivSelect,
    output logic transmitEnergize,
    output logic spareOutput,
    output logic rxAudioGround,
    output logic modulatedTxGround,
    output logic antennaTxSelect,
    output logic transmitSupplyLine,
    output logic receiveSupplyLine,
    output logic toneOscEnable
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);   // Hold counter width
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYCLES);
    localparam int NSYNC = 5;                          // Pins needing synchronisers

    logic [NSYNC-1:0] pinRaw;      // Raw asynchronous pins
    logic [NSYNC-1:0] meta_reg;    // First synchroniser stage
    logic [NSYNC-1:0] sync_reg;    // Second synchroniser stage
    logic clkPrev_reg;             // Previous synced serial clock
    logic strobePrev_reg;          // Previous synced load strobe
    logic tonePrev_reg;            // Previous synced tone key
    logic serClkSync;              // Synced serial clock
    logic dataSync;                // Synced serial data
    logic strobeSync;              // Synced load strobe
    logic pttSync;                 // Synced push-to-talk, high when closed
    logic toneSync;                // Synced tone key, high when closed
    logic strobeRise;              // Rising edge of load strobe
    logic toneFall;                // Tone key just released
    logic [7:0] latch_reg;         // Decoding output stage contents
    logic [HOLD_W-1:0] hold_reg;   // Remaining tone hold cycles
    logic keyed;                   // Transmit request from any source
    logic keyed_reg;               // Registered transmit state

    shift_link_if lnk ();          // Link to the shift stage

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    assign pinRaw = {toneKeyInput, pushToTalk, controlLoadStrobe, serialData, serialClk};

    // Two flops per pin; the first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                end else begin
                    meta_reg[gi] <= pinRaw[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    assign serClkSync = sync_reg[0];
    assign dataSync = sync_reg[1];
    assign strobeSync = sync_reg[2];
    assign pttSync = sync_reg[3];
    assign toneSync = sync_reg[4];

    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    // Previous values of the synced levels
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            clkPrev_reg <= 1'b0;
            strobePrev_reg <= 1'b0;
            tonePrev_reg <= 1'b0;
        end else begin
            clkPrev_reg <= serClkSync;
            strobePrev_reg <= strobeSync;
            tonePrev_reg <= toneSync;
        end
    end

    assign lnk.shiftRise = serClkSync & ~clkPrev_reg;
    assign lnk.shiftData = dataSync;
    assign strobeRise = strobeSync & ~strobePrev_reg;
    assign toneFall = tonePrev_reg & ~toneSync;

    // ----------------------------------------------------------------
    // Serial shift stage
    // ----------------------------------------------------------------
    serial_shift_stage u_shift (
        .sys_clk (sys_clk),
        .srst (srst),
        .lnk (lnk.stage)
    );

    // ----------------------------------------------------------------
    // Decoding output stage
    // ----------------------------------------------------------------
    // Copy the shifted word on the strobe edge only; a frame that is
    // still being shifted never disturbs the outputs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            latch_reg <= sfcl_pkg::LATCH_REST;
        end else if (strobeRise) begin
            latch_reg <= lnk.word;
        end
    end

    // Outputs come straight from the latch flops
    // reduced power select
    assign lowPowerSelect = latch_reg[sfcl_pkg::LOW_POWER_BIT];
    assign squelchHoldEnable_n = latch_reg[sfcl_pkg::SQUELCH_HOLD_BIT];
    assign txAudioMute_n = latch_reg[sfcl_pkg::TX_MUTE_BIT];
    assign amEquivSelect = latch_reg[sfcl_pkg::AM_EQUIV_BIT];
    assign transmitEnergize = latch_reg[sfcl_pkg::TX_ENERGIZE_BIT];
    assign rxAudioGround = latch_reg[sfcl_pkg::RX_GROUND_BIT];
    assign modulatedTxGround = latch_reg[sfcl_pkg::MOD_GROUND_BIT];

    // Spare is pinned high whatever the frame carries
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            spareOutput <= 1'b1;
        end else begin
            spareOutput <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Tone key hold timer
    // ----------------------------------------------------------------
    // Restarted on each release so short gaps between key strokes
    // do not chatter the transmit relay
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hold_reg <= '0;
        end else if (toneSync) begin
            hold_reg <= '0;
        end else if (toneFall) begin
            hold_reg <= HOLD_LOAD;
        end else if (hold_reg != '0) begin
            hold_reg <= hold_reg - HOLD_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // Transmit/receive switching
    // ----------------------------------------------------------------
    // tone key keys transmitter
    assign keyed = pttSync | toneSync | toneFall | (hold_reg != '0);

    // Antenna and supply lines follow the combined transmit request
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            keyed_reg <= 1'b0;
            antennaTxSelect <= 1'b0;
            transmitSupplyLine <= 1'b0;
            receiveSupplyLine <= 1'b1;
        end else begin
            keyed_reg <= keyed;
            antennaTxSelect <= keyed;
            transmitSupplyLine <= keyed;
            receiveSupplyLine <= ~keyed;
        end
    end

    // Oscillator runs for the latched command or the tone key
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            toneOscEnable <= 1'b0;
        end else begin
            toneOscEnable <= toneSync | latch_reg[sfcl_pkg::TX_ENERGIZE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    load_word_a: assert property (@(posedge sys_clk) disable iff (srst)
        strobeRise |=> latch_reg == $past(lnk.word))
        else $error("latch did not take the shifted word");
    latch_stable_a: assert property (@(posedge sys_clk) disable iff (srst)
        !strobeRise |=> $stable(latch_reg))
        else $error("latch changed without a strobe");
    low_power_a: assert property (@(posedge sys_clk) disable iff (srst)
        strobeRise |=> lowPowerSelect == $past(lnk.word[0]))
        else $error("power select wrong after load");
    squelch_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        strobeRise |=> squelchHoldEnable_n == $past(lnk.word[1]))
        else $error("squelch hold wrong after load");
    tx_mute_a: assert property (@(posedge sys_clk) disable iff (srst)
        strobeRise |=> txAudioMute_n == $past(lnk.word[2]))
        else $error("transmit mute wrong after load");
    am_equiv_a: assert property (@(posedge sys_clk) disable iff (srst)
        strobeRise |=> amEquivSelect == $past(lnk.word[3]))
        else $error("AM-equivalent select wrong after load");
    tx_energize_a: assert property (@(posedge sys_clk) disable iff (srst)
        transmitEnergize |=> toneOscEnable)
        else $error("oscillator not energized");
    ground_bits_a: assert property (@(posedge sys_clk) disable iff (srst)
        strobeRise |=> rxAudioGround == $past(lnk.word[6])
            && modulatedTxGround == $past(lnk.word[7]))
        else $error("audio ground outputs wrong after load");
    rest_reset_a: assert property (@(posedge sys_clk)
        srst |=> latch_reg == sfcl_pkg::LATCH_REST && spareOutput && receiveSupplyLine)
        else $error("outputs not at rest after reset");
    ptt_switch_a: assert property (@(posedge sys_clk) disable iff (srst)
        pttSync |=> antennaTxSelect && transmitSupplyLine && !receiveSupplyLine)
        else $error("push-to-talk did not switch to transmit");
    supply_excl_a: assert property (@(posedge sys_clk) disable iff (srst)
        transmitSupplyLine != receiveSupplyLine)
        else $error("supply lines not exclusive");
    tone_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        toneFall |=> transmitSupplyLine [*8])
        else $error("transmit dropped during tone hold");
    hold_bound_a: assert property (@(posedge sys_clk) disable iff (srst)
        hold_reg <= HOLD_LOAD)
        else $error("hold counter beyond its load value");

    load_seen_c: cover property (@(posedge sys_clk) disable iff (srst) strobeRise);
    ptt_seen_c: cover property (@(posedge sys_clk) disable iff (srst) $rose(transmitSupplyLine));
    hold_end_c: cover property (@(posedge sys_clk) disable iff (srst)
        hold_reg == HOLD_W'(1) && keyed_reg);

endmodule // serial_function_control_latch

/* File: rtl/sfcl_pkg.sv */
// Constants shared by the serial function control latch design
package sfcl_pkg;

    // ----------------------------------------------------------------
    // Frame and latch layout
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 8;                 // Bits in one control frame
    localparam int LOW_POWER_BIT = 0;              // Output one
    localparam int SQUELCH_HOLD_BIT = 1;           // Output two, active low
    localparam int TX_MUTE_BIT = 2;                // Output three, active low
    localparam int AM_EQUIV_BIT = 3;               // Output four
    localparam int TX_ENERGIZE_BIT = 4;            // Output five
    localparam int SPARE_BIT = 5;                  // Output six, unused
    localparam int RX_GROUND_BIT = 6;              // Output seven
    localparam int MOD_GROUND_BIT = 7;             // Output eight
    localparam logic [7:0] LATCH_REST = 8'h26;     // Rest levels of all outputs

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 40;                   // System clock rate
    localparam int TONE_HOLD_US = 20000;           // Transmit hold after tone key release
    localparam int TONE_HOLD_CYCLES = TONE_HOLD_US * CLK_MHZ;

endpackage

/* File: rtl/shift_link_if.sv */
// Link between the control latch top and its serial shift stage
`timescale 1ns/1ps
interface shift_link_if;
    logic shiftRise;    // One-cycle pulse on a rising serial clock edge
    logic shiftData;    // Synchronised serial data bit
    logic [7:0] word;   // Current shift register contents

    modport stage (input shiftRise, input shiftData, output word);
    modport top (output shiftRise, output shiftData, input word);
endinterface

/* File: rtl/serial_shift_stage.sv */
// Eight-bit serial shift stage clocked by serial clock edge pulses
`timescale 1ns/1ps
module serial_shift_stage (
    input wire logic sys_clk,
    input wire logic srst,
    shift_link_if.stage lnk
);

    // ----------------------------------------------------------------
    // Shift register
    // ----------------------------------------------------------------
    logic [7:0] shift_reg;    // Bits shifted in so far

    // Shift on each rising serial edge; first bit travels to the top
    // shift data in
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            shift_reg <= 8'h00;
        end else if (lnk.shiftRise) begin
            shift_reg <= {shift_reg[6:0], lnk.shiftData};
        end
    end

    assign lnk.word = shift_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    shift_order_a: assert property (@(posedge sys_clk) disable iff (srst)
        lnk.shiftRise |=> shift_reg == {$past(shift_reg[6:0]), $past(lnk.shiftData)})
        else $error("shift stage did not shift");
    shift_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        !lnk.shiftRise |=> $stable(shift_reg))
        else $error("shift stage moved without a clock edge");

endmodule // serial_shift_stage

/* File: tb/proc_model.sv */
// Behavioural supervising processor driving the serial control pins
`timescale 1ns/1ps
module proc_model (
    input wire logic sys_clk,
    output logic serialClk,
    output logic serialData,
    output logic controlLoadStrobe
);
    // Pins idle at time zero: serial clock parked low, strobe low
    initial begin
        serialClk = 1'b0;
        serialData = 1'b0;
        controlLoadStrobe = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame sender
    // ------------------------------------------------------------
    // first bit shifted first
    task automatic send_word(input logic [7:0] w, input logic load);
        for (int i = 7; i >= 0; i--) begin
            @(posedge sys_clk);
            serialClk <= 1'b0;
            serialData <= w[i];
            // Data set four system clock cycles ahead of the rising edge
            repeat (4) @(posedge sys_clk);
            serialClk <= 1'b1;
            repeat (4) @(posedge sys_clk);
        end
        // Clock stands still between frames
        serialClk <= 1'b0;
        // Released data line shows the inverse so a stale bit never matches
        serialData <= ~w[0];
        if (load) begin
            repeat (4) @(posedge sys_clk);
            controlLoadStrobe <= 1'b1;
            repeat (4) @(posedge sys_clk);
            controlLoadStrobe <= 1'b0;
        end
        // Margin so outputs have settled when the caller looks
        repeat (6) @(posedge sys_clk);
    endtask
endmodule // proc_model

/* File: tb/serial_function_control_latch_tb.sv */
// Self-checking bench for the serial function control latch
`timescale 1ns/1ps
module serial_function_control_latch_tb;
    localparam int HOLD = 50; // Short tone hold so the run stays brief
    logic sys_clk = 1'b0; // System clock, 40 MHz
    logic srst = 1'b1; // Synchronous reset, held at start
    logic pushToTalk; // Talk switch pin
    logic toneKeyInput; // Tone key pin
    logic serialClk, serialData, controlLoadStrobe; // Driven by the processor model
    logic lowPowerSelect, squelchHoldEnable_n, txAudioMute_n, amEquivSelect;
    logic transmitEnergize, spareOutput, rxAudioGround, modulatedTxGround;
    logic antennaTxSelect, transmitSupplyLine, receiveSupplyLine, toneOscEnable;
    logic [7:0] outVec; // Latched outputs gathered in bit order
    int errorCnt = 0; // Mismatches seen
    int testsRun = 0; // Comparisons made

    assign outVec = {modulatedTxGround, rxAudioGround, spareOutput, transmitEnergize,
                     amEquivSelect, txAudioMute_n, squelchHoldEnable_n, lowPowerSelect};

    // Clock generator
    always #12.5 sys_clk = ~sys_clk;

    serial_function_control_latch #(.HOLD_CYCLES(HOLD)) dut_u (
        .sys_clk(sys_clk), .srst(srst), .serialClk(serialClk), .serialData(serialData),
        .controlLoadStrobe(controlLoadStrobe), .pushToTalk(pushToTalk),
        .toneKeyInput(toneKeyInput), .lowPowerSelect(lowPowerSelect),
        .squelchHoldEnable_n(squelchHoldEnable_n), .txAudioMute_n(txAudioMute_n),
        .amEquivSelect(amEquivSelect), .transmitEnergize(transmitEnergize),
        .spareOutput(spareOutput), .rxAudioGround(rxAudioGround),
        .modulatedTxGround(modulatedTxGround), .antennaTxSelect(antennaTxSelect),
        .transmitSupplyLine(transmitSupplyLine), .receiveSupplyLine(receiveSupplyLine),
        .toneOscEnable(toneOscEnable)
    );

    proc_model proc_u (
        .sys_clk(sys_clk), .serialClk(serialClk), .serialData(serialData),
        .controlLoadStrobe(controlLoadStrobe)
    );

    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    // Latched output word against expectation
    task automatic checkVec(input string what, input logic [7:0] exp, input logic [7:0] got);
        testsRun++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Single control line against expectation
    task automatic checkBit(input string what, input logic exp, input logic got);
        testsRun++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Supply pair: transmit line and its receive complement
    task automatic checkSupply(input logic tx);
        checkBit("tx supply", tx, transmitSupplyLine);
        checkBit("rx supply", ~tx, receiveSupplyLine);
    endtask

    // Verdict and end of run
    task automatic testDone();
        if (errorCnt == 0 && testsRun > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] w;
        pushToTalk = 1'b0;
        toneKeyInput = 1'b0;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        // Look mid-cycle so every output launched at the last edge has settled
        @(negedge sys_clk);
        checkVec("rest word", 8'h26, outVec);
        checkBit("osc idle", 1'b0, toneOscEnable);
        checkSupply(1'b0);
        // A shifted word must not reach the outputs without a strobe
        proc_u.send_word(8'hD9, 1'b0);
        @(negedge sys_clk);
        checkVec("no strobe", 8'h26, outVec);
        // Walking one and walking zero exercise each output polarity; spare stays high
        for (int i = 0; i < 8; i++) begin
            w = 8'h01 << i;
            proc_u.send_word(w, 1'b1);
            @(negedge sys_clk);
            checkVec("walk one", w | 8'h20, outVec);
            checkBit("osc by word", w[4], toneOscEnable);
            w = ~w;
            proc_u.send_word(w, 1'b1);
            @(negedge sys_clk);
            checkVec("walk zero", w | 8'h20, outVec);
            checkBit("osc by word", w[4], toneOscEnable);
        end
        // Reset in mid-run restores the rest levels; last word left the oscillator on
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        checkVec("rest again", 8'h26, outVec);
        checkBit("osc idle again", 1'b0, toneOscEnable);
        // Talk switch closes then opens
        @(posedge sys_clk);
        pushToTalk <= 1'b1;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        checkBit("antenna tx", 1'b1, antennaTxSelect);
        checkSupply(1'b1);
        @(posedge sys_clk);
        pushToTalk <= 1'b0;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        checkBit("antenna rx", 1'b0, antennaTxSelect);
        checkSupply(1'b0);
        @(posedge sys_clk);
        toneKeyInput <= 1'b1;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        checkSupply(1'b1);
        checkBit("antenna tone", 1'b1, antennaTxSelect);
        checkBit("osc keyed", 1'b1, toneOscEnable);
        @(posedge sys_clk);
        toneKeyInput <= 1'b0;
        repeat (HOLD / 2) @(posedge sys_clk);
        @(negedge sys_clk);
        checkSupply(1'b1);
        repeat (HOLD) @(posedge sys_clk);
        @(negedge sys_clk);
        checkSupply(1'b0);
        checkBit("osc off", 1'b0, toneOscEnable);
        testDone();
    end

    // Watchdog: the sequence needs about 1600 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        errorCnt++;
        testDone();
    end
endmodule // serial_function_control_latch_tb
